// ===== logic/sie_stage_irq.v
// stage interrupt enables: threshold and conversion-done sources onto int_n
// assumes stage conditions are synchronous level/pulse inputs on clk
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sie_defs.vh"

module sie_stage_irq (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire [`SIE_ADDR_W-1:0] awaddr,
   input  wire                   awvalid,
   output wire                   awready,
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output wire                   wready,
   output wire [1:0]             bresp,
   output wire                   bvalid,
   input  wire                   bready,
   input  wire [`SIE_ADDR_W-1:0] araddr,
   input  wire                   arvalid,
   output wire                   arready,
   output wire [31:0]            rdata,
   output wire [1:0]             rresp,
   output wire                   rvalid,
   input  wire                   rready,
   input  wire [11:0]            highLimit,
   input  wire                   limitA,
   input  wire [11:0]            convDone,
   output wire                   int_n,
   output wire                   irq
);

   reg  [15:0]            highEn_r;
   reg  [15:0]            doneEn_r;
   reg  [1:0]             status_r;
   reg  [1:0]             mask_r;
   reg  [11:0]            donePend_r;
   wire                   wrStb;
   wire [`SIE_ADDR_W-1:0] wrAddr;
   wire [31:0]            wrData;
   wire [3:0]             wrStrb;
   wire                   rdStb;
   wire [`SIE_ADDR_W-1:0] rdAddr;
   reg  [31:0]            rdData;
   reg                    rdOk;
   reg                    wrOk;
   wire [11:0]            highSrc;
   wire                   highHit;
   wire                   doneHit;
   wire [11:0]            doneNew;
   wire                   srcAny;
   wire                   rdStatus;

   // byte-lane merge of a 16-bit register under write strobes
   function [15:0] laneMerge;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         laneMerge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
         laneMerge[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   sie_axil_slave u_bus (
      .clk     (clk),
      .rst_n   (rst_n),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrStb   (wrStb),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .wrOk    (wrOk),
      .rdStb   (rdStb),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdOk    (rdOk)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   always @* begin
      wrOk = 1'b1;
      if (wrAddr == `SIE_ADDR_HIGH_EN) begin
         wrOk = 1'b1;
      end else if (wrAddr == `SIE_ADDR_DONE_EN) begin
         wrOk = 1'b1;
      end else if (wrAddr == `SIE_ADDR_MASK) begin
         wrOk = 1'b1;
      end else if (wrAddr == `SIE_ADDR_STATUS) begin
         wrOk = 1'b1;
      end else begin
         wrOk = 1'b0;
      end
   end

   always @* begin
      rdData = 32'h00000000;
      rdOk   = 1'b1;
      if (rdAddr == `SIE_ADDR_HIGH_EN) begin
         rdData = {16'h0000, highEn_r};
      end else if (rdAddr == `SIE_ADDR_DONE_EN) begin
         rdData = {16'h0000, doneEn_r};
      end else if (rdAddr == `SIE_ADDR_STATUS) begin
         rdData = {30'h00000000, status_r};
      end else if (rdAddr == `SIE_ADDR_MASK) begin
         rdData = {30'h00000000, mask_r};
      end else begin
         rdOk = 1'b0;
      end
   end

   assign rdStatus = rdStb && (rdAddr == `SIE_ADDR_STATUS);

   // ----------------------------------------
   // enable and mask registers
   // ----------------------------------------
   // unused bits (high enable 7:0 and 15:12, done enable 15:12) are not stored, so a careless host write cannot arm them
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         highEn_r <= `SIE_EN_RESET;
         doneEn_r <= `SIE_EN_RESET;
         mask_r   <= `SIE_MASK_RESET;
      end else if (wrStb) begin
         if (wrAddr == `SIE_ADDR_HIGH_EN) begin
            highEn_r <= laneMerge(highEn_r, wrData, wrStrb) & `SIE_HIGH_USED;
         end else if (wrAddr == `SIE_ADDR_DONE_EN) begin
            doneEn_r <= laneMerge(doneEn_r, wrData, wrStrb) & `SIE_DONE_USED;
         end else if (wrAddr == `SIE_ADDR_MASK) begin
            if (wrStrb[0]) begin
               mask_r <= wrData[1:0];
            end
         end
      end
   end

   // ----------------------------------------
   // sources
   // ----------------------------------------
   // bit 9 watches the stage 10 low limit rather than a stage 9 high limit
   assign highSrc = {highLimit[11:10], limitA, highLimit[8:0]};
   assign highHit = |(highSrc & highEn_r[`SIE_STAGE_MSB:0]);
   // enabled completions this cycle, shared by pending and status logic
   assign doneNew = convDone & doneEn_r[`SIE_STAGE_MSB:0];

   // completion is a pulse, held pending until software reads status
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         donePend_r <= `SIE_PEND_RESET;
      end else if (rdStatus) begin
         donePend_r <= doneNew;
      end else begin
         donePend_r <= donePend_r | doneNew;
      end
   end

   assign doneHit = |donePend_r;
   assign srcAny  = highHit || doneHit;
   assign int_n   = !srcAny;

   // ----------------------------------------
   // sticky status, cleared by read; set wins
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= `SIE_STAT_RESET;
      end else begin
         status_r[`SIE_EV_HIGH] <= (status_r[`SIE_EV_HIGH] && !rdStatus) || highHit;
         status_r[`SIE_EV_DONE] <= (status_r[`SIE_EV_DONE] && !rdStatus) || (|doneNew);
      end
   end

   assign irq = |(status_r & ~mask_r);

endmodule // sie_stage_irq

// ===== logic/sie_defs.vh
// constants for the stage interrupt enable block
// assumes a 32-bit axi4-lite register bus and a 25 MHz clock
`ifndef SIE_DEFS_VH
`define SIE_DEFS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define SIE_IDX_HIGH_EN      12'h006
`define SIE_IDX_DONE_EN      12'h007
`define SIE_IDX_STATUS       12'h020
`define SIE_IDX_MASK         12'h021
`define SIE_ADDR_W           14
`define SIE_ADDR_HIGH_EN     14'h0018
`define SIE_ADDR_DONE_EN     14'h001c
`define SIE_ADDR_STATUS      14'h0080
`define SIE_ADDR_MASK        14'h0084

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define SIE_STAGES           12
`define SIE_HIGH_USED        16'h0f00
`define SIE_DONE_USED        16'h0fff
`define SIE_BIT_LIMIT_A      9
`define SIE_EN_RESET         16'h0000
`define SIE_MASK_RESET       2'h3
`define SIE_STAT_RESET       2'h0
`define SIE_PEND_RESET       12'h000
`define SIE_STAGE_MSB        11
`define SIE_EV_HIGH          0
`define SIE_EV_DONE          1
`define SIE_RESP_OKAY        2'h0
`define SIE_RESP_SLVERR      2'h2

`endif

// ===== logic/sie_axil_slave.v
// axi4-lite slave front end: accepts one write and one read at a time
// assumes a single clock and a master that keeps valid until taken
`timescale 1ns/1ps
`include "sie_defs.vh"

module sie_axil_slave (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire [`SIE_ADDR_W-1:0] awaddr,
   input  wire                   awvalid,
   output wire                   awready,
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output wire                   wready,
   output reg  [1:0]             bresp,
   output reg                    bvalid,
   input  wire                   bready,
   input  wire [`SIE_ADDR_W-1:0] araddr,
   input  wire                   arvalid,
   output wire                   arready,
   output reg  [31:0]            rdata,
   output reg  [1:0]             rresp,
   output reg                    rvalid,
   input  wire                   rready,
   output wire                   wrStb,
   output wire [`SIE_ADDR_W-1:0] wrAddr,
   output wire [31:0]            wrData,
   output wire [3:0]             wrStrb,
   input  wire                   wrOk,
   output wire                   rdStb,
   output wire [`SIE_ADDR_W-1:0] rdAddr,
   input  wire [31:0]            rdData,
   input  wire                   rdOk
);

   reg                   awHave_r;
   reg                   wHave_r;
   reg [`SIE_ADDR_W-1:0] awAddr_r;
   reg [31:0]            wData_r;
   reg [3:0]             wStrb_r;

   // ----------------------------------------
   // write channels, taken in either order
   // ----------------------------------------
   assign awready = !awHave_r && !bvalid;
   assign wready  = !wHave_r && !bvalid;
   assign wrStb   = awHave_r && wHave_r;
   assign wrAddr  = awAddr_r;
   assign wrData  = wData_r;
   assign wrStrb  = wStrb_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHave_r <= 1'b0;
         wHave_r  <= 1'b0;
         awAddr_r <= {`SIE_ADDR_W{1'b0}};
         wData_r  <= 32'h00000000;
         wStrb_r  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= `SIE_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (wrStb) begin
            awHave_r <= 1'b0;
            wHave_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= wrOk ? `SIE_RESP_OKAY : `SIE_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   assign arready = !rvalid;
   assign rdStb   = arvalid && arready;
   assign rdAddr  = araddr;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `SIE_RESP_OKAY;
      end else if (rdStb) begin
         rvalid <= 1'b1;
         rdata  <= rdData;
         rresp  <= rdOk ? `SIE_RESP_OKAY : `SIE_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule // sie_axil_slave

// ===== dv/sie_stage_irq_sva.sv
// checker for the stage interrupt enable block, bound to its top module
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module sie_stage_irq_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [11:0] highLimit,
   input wire logic        limitA,
   input wire logic [11:0] convDone,
   input wire logic        int_n
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence wrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence intCause;
      |highLimit || limitA || $past(|convDone);
   endsequence
   a_reset_int_idle: assert property ($past(!rst_n) |-> int_n) else $error("int low at reset exit");
   a_write_answer: assert property (wrTaken |=> ##[1:2] bvalid) else $error("write not answered");
   a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
   a_bresp_once: assert property (bvalid && bready |=> !bvalid) else $error("write answer repeated");
   a_rresp_once: assert property (rvalid && rready |=> !rvalid) else $error("read answer repeated");
   a_read_refused: assert property (rvalid |-> !arready) else $error("read taken while answering");
   a_write_refused: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
   // a fall needs a level source now or a done pulse one cycle before
   a_int_cause: assert property ($fell(int_n) |-> intCause) else $error("int fell with no source");
endmodule // sie_stage_irq_sva

// ===== dv/sie_stage_src.sv
// stage condition source standing in for the converter core
// assumes the bench commands it just after rising clock edges
`timescale 1ns/1ps
module sie_stage_src (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] cmdHigh,
   input  wire logic        cmdLimA,
   input  wire logic [11:0] cmdDone,
   output logic      [11:0] highLimit,
   output logic             limitA,
   output logic      [11:0] convDone
);
   // one register stage, so done stays a single-cycle pulse
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         highLimit <= 12'h000;
         limitA <= 1'h0;
         convDone <= 12'h000;
      end else begin
         highLimit <= cmdHigh;
         limitA <= cmdLimA;
         convDone <= cmdDone;
      end
   end
endmodule // sie_stage_src

// ===== dv/stage_interrupt_enables_tb.sv
// testbench for the stage interrupt enable block
// assumes the design, checker and source model are compiled first
`timescale 1ns/1ps
`include "sie_defs.vh"
module stage_interrupt_enables_tb;
   logic        clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0, cmdLimA = 1'h0;
   logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   logic [31:0] wdata = 32'h0;
   logic [11:0] cmdHigh = 12'h000, cmdDone = 12'h000;
   wire         awready, wready, bvalid, arready, rvalid, limitA, int_n, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [11:0] highLimit, convDone;
   int          miscompares = 0, testsRun = 0;
   always #20 clk = ~clk;
   sie_stage_irq dut_u (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .highLimit(highLimit), .limitA(limitA), .convDone(convDone),
      .int_n(int_n), .irq(irq));
   sie_stage_src src_u (.clk(clk), .rst_n(rst_n), .cmdHigh(cmdHigh), .cmdLimA(cmdLimA), .cmdDone(cmdDone),
      .highLimit(highLimit), .limitA(limitA), .convDone(convDone));
   // ----
   // shared tasks
   // ----
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // ready is read at the falling edge, so it equals what the next rising edge samples
   task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      aw = 1'h1;
      w = 1'h1;
      b = 1'h0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!b) begin
         @(negedge clk);
         b = bvalid;
         if (b) chk("bresp", 32'(er), 32'(bresp));
         if (awready) aw = 1'h0;
         if (wready) w = 1'h0;
         @(posedge clk);
         awvalid <= aw;
         wvalid <= w;
      end
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar, r;
      ar = 1'h1;
      r = 1'h0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!r) begin
         @(negedge clk);
         r = rvalid;
         if (r) chk("rdata", e, rdata);
         if (r) chk("rresp", 32'(er), 32'(rresp));
         if (arready) ar = 1'h0;
         @(posedge clk);
         arvalid <= ar;
      end
      rready <= 1'h0;
   endtask
   task automatic src(input logic [11:0] h, input logic l, input logic [11:0] d);
      @(posedge clk);
      cmdHigh <= h;
      cmdLimA <= l;
      cmdDone <= d;
      @(posedge clk);
      cmdDone <= 12'h000;
      @(posedge clk);
      @(negedge clk);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_regs;
      chk("int_n", 32'h1, 32'(int_n));
      rd(`SIE_ADDR_HIGH_EN, 32'h0, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_DONE_EN, 32'h0, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_MASK, 32'h3, `SIE_RESP_OKAY);
      wr(`SIE_ADDR_DONE_EN, 32'h0fff, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_DONE_EN, 32'h0fff, `SIE_RESP_OKAY);
      wr(`SIE_ADDR_HIGH_EN, 32'h0f00, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_HIGH_EN, 32'h0f00, `SIE_RESP_OKAY);
      wr(14'h0040, 32'h1, `SIE_RESP_SLVERR);
      rd(14'h0040, 32'h0, `SIE_RESP_SLVERR);
      wr(`SIE_ADDR_DONE_EN, 32'h0, `SIE_RESP_OKAY);
   endtask
   // bit 9 answers the stage 10 low limit, never stage 9 high
   task automatic t_high;
      logic [11:0] other;
      for (int s = 8; s < 12; s++) begin
         other = (s == 9) ? 12'hfff : ~(12'h1 << s);
         wr(`SIE_ADDR_HIGH_EN, 32'h1 << s, `SIE_RESP_OKAY);
         src(other, s != 9, 12'h000);
         chk("int_n", 32'h1, 32'(int_n));
         src(12'hfff, 1'h1, 12'h000);
         chk("int_n", 32'h0, 32'(int_n));
         src(12'h000, 1'h0, 12'h000);
         chk("int_n", 32'h1, 32'(int_n));
      end
      wr(`SIE_ADDR_HIGH_EN, 32'h0, `SIE_RESP_OKAY);
   endtask
   task automatic t_done;
      rd(`SIE_ADDR_STATUS, 32'h1, `SIE_RESP_OKAY);
      for (int s = 0; s < 12; s++) begin
         wr(`SIE_ADDR_DONE_EN, 32'h1 << s, `SIE_RESP_OKAY);
         src(12'h000, 1'h0, ~(12'h1 << s));
         chk("int_n", 32'h1, 32'(int_n));
         src(12'h000, 1'h0, 12'h1 << s);
         chk("int_n", 32'h0, 32'(int_n));
         chk("irq", 32'h0, 32'(irq));
         rd(`SIE_ADDR_STATUS, 32'h2, `SIE_RESP_OKAY);
         @(negedge clk);
         chk("int_n", 32'h1, 32'(int_n));
      end
   endtask
   task automatic t_or;
      wr(`SIE_ADDR_MASK, 32'h0, `SIE_RESP_OKAY);
      wr(`SIE_ADDR_HIGH_EN, 32'h0100, `SIE_RESP_OKAY);
      wr(`SIE_ADDR_DONE_EN, 32'h0001, `SIE_RESP_OKAY);
      src(12'h100, 1'h0, 12'h001);
      chk("int_n", 32'h0, 32'(int_n));
      chk("irq", 32'h1, 32'(irq));
      src(12'h000, 1'h0, 12'h000);
      chk("int_n", 32'h0, 32'(int_n));
      rd(`SIE_ADDR_STATUS, 32'h3, `SIE_RESP_OKAY);
      @(negedge clk);
      chk("int_n", 32'h1, 32'(int_n));
      chk("irq", 32'h0, 32'(irq));
   endtask
   // a mid-run reset must drop every enable back to zero
   task automatic t_reset;
      wr(`SIE_ADDR_HIGH_EN, 32'h0f00, `SIE_RESP_OKAY);
      wr(`SIE_ADDR_DONE_EN, 32'h0fff, `SIE_RESP_OKAY);
      src(12'h400, 1'h0, 12'h000);
      chk("int_n", 32'h0, 32'(int_n));
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      chk("int_n", 32'h1, 32'(int_n));
      chk("irq", 32'h0, 32'(irq));
      rd(`SIE_ADDR_HIGH_EN, 32'h0, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_DONE_EN, 32'h0, `SIE_RESP_OKAY);
      rd(`SIE_ADDR_MASK, 32'h3, `SIE_RESP_OKAY);
      src(12'h000, 1'h0, 12'h000);
      chk("int_n", 32'h1, 32'(int_n));
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      t_regs;
      t_high;
      t_done;
      t_or;
      t_reset;
      close_out;
   end
   // whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out;
   end
endmodule // stage_interrupt_enables_tb
bind sie_stage_irq sie_stage_irq_sva chk_u (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .highLimit(highLimit), .limitA(limitA), .convDone(convDone), .int_n(int_n));
